// ===== inc/tie2_pkg.sv
// constants and types of the timer interrupt-enable and channel 2 A io-mode block
// assumes a 32-bit AXI4-Lite bus with an 8-bit byte address
package tie2_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 4;
  localparam int HI_LSB = 5;
  localparam logic [2:0] ADDR_HI_ZERO = 3'h0;
  localparam logic [2:0] IDX_IEN0 = 3'h0; // irq_enable_ch0 at 0x00, ch1 0x04, ch2 0x08
  localparam logic [2:0] IDX_IOCTL = 3'h3; // ch2_io_control at 0x0c
  localparam logic [2:0] IDX_STAT0 = 3'h4; // timer_status_reg ch0 at 0x10, ch1 0x14, ch2 0x18
  localparam logic [2:0] IDX_GENA = 3'h7; // ch2_general_reg_a at 0x1c
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IEN_FIXED = 8'h40; // bit 6 reads 1, bit 7 reads 0
  localparam logic [7:0] IEN_MASK_CH0 = 8'h1f;
  localparam logic [7:0] IEN_MASK_CH12 = 8'h33;
  localparam logic [7:0] STAT_FIXED = 8'hc0;
  localparam logic [5:0] FLAG_MASK_CH0 = 6'h1f;
  localparam logic [5:0] FLAG_MASK_CH12 = 6'h33;
  localparam logic [5:0] FLAG_NONE = 6'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] GENA_RESET = 16'hffff;

  // select field modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LOW = 2'h1;
  localparam logic [1:0] MODE_HIGH = 2'h2;
  localparam logic [1:0] MODE_TOGGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel_a_bit3; // 1 = input capture
    logic sel_a_bit2; // initial output level
    logic [1:0] mode; // sel_a_bit1, sel_a_bit0
  } tie2_sel_t;

  localparam tie2_sel_t SEL_RESET = 4'h0;

  typedef struct packed {
    logic underflow_flag;
    logic overflow_flag;
    logic gen_d_match_flag;
    logic gen_c_match_flag;
    logic gen_b_match_flag;
    logic gen_a_match_flag;
  } tie2_flags_t;

endpackage

// ===== src/tie2_top.sv
// interrupt enables, status flags and channel 2 A io mode of a three-channel 16-bit timer
// assumes counter values and other capture/compare events come in synchronous to CLK
//
// Function
// - compare mode 01: pin goes low on each match, starting at bit 2 level
// - compare mode 10: pin goes high on each match, starting at bit 2 level
// - compare mode 11: pin toggles on each match, starting at bit 2 level
// - select 1x00: capture counter on pin rising edge, bit 2 ignored
// - select 1x01: capture counter on pin falling edge
// - select 1x1x: capture counter on both pin edges
// - three 8-bit enable registers, one per channel, reset to 40 hex
// - enable bit 7 reads 0; software writes 0
// - enable bit 6 reads 1; software writes 1
// - channels 1 and 2: bit 5 gates underflow request
// - channel 0: enable bit 5 reserved, reads 0, writes ignored
// - every channel: bit 4 gates overflow request
// - channel 0: bit 3 gates D register flag request
// - channels 1 and 2: enable bit 3 reserved, reads 0
// - channel 0: bit 2 gates C register flag request
// - channels 1 and 2: enable bit 2 reserved, reads 0
// - every channel: bit 1 gates B register flag request
// - every channel: bit 0 gates A register flag request
// - flag clears on write 0 after read as 1; write 1 keeps it
// - overflow flag sets when counter wraps from all ones to zero
// - underflow flag sets in channels 1 and 2 on wrap zero to all ones
// - match flag sets on compare equality or on capture load
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module tie2_top (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [15:0] TIMER_COUNT0,
  input wire logic [15:0] TIMER_COUNT1,
  input wire logic [15:0] TIMER_COUNT2,
  input wire logic [3:0] CH0_GEN_EVT,
  input wire logic [1:0] CH1_GEN_EVT,
  input wire logic CH2_GEN_B_EVT,
  input wire logic CH2_PIN_A_I,
  output logic CH2_PIN_A_O,
  output logic CH2_PIN_A_OE,
  output logic [2:0] GEN_A_IRQ,
  output logic [2:0] GEN_B_IRQ,
  output logic GEN_C_IRQ,
  output logic GEN_D_IRQ,
  output logic [2:0] OVERFLOW_IRQ,
  output logic [1:0] UNDERFLOW_IRQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_do;
  logic wr_map;
  logic [2:0] wr_idx;
  logic rd_do;
  logic rd_map;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  logic [7:0] ien_ff [tie2_pkg::NUM_CH];
  tie2_pkg::tie2_flags_t flag_ff [tie2_pkg::NUM_CH];
  logic [5:0] armed_ff [tie2_pkg::NUM_CH];
  logic [5:0] irq_ff [tie2_pkg::NUM_CH];
  logic [15:0] cnt [tie2_pkg::NUM_CH];
  logic [15:0] cnt_prev_ff [tie2_pkg::NUM_CH];
  logic [3:0] gen_evt [tie2_pkg::NUM_CH];
  logic started_ff;
  tie2_pkg::tie2_sel_t sel_ff;
  tie2_pkg::tie2_sel_t nxt_sel;
  logic [15:0] gena_ff;
  logic pin_prev_ff;
  logic out_lvl_ff;
  logic oe_ff;
  logic pin_rise;
  logic pin_fall;
  logic cmp_match;
  logic cap_edge;
  logic ioctl_wr;

  assign cnt[0] = TIMER_COUNT0;
  assign cnt[1] = TIMER_COUNT1;
  assign cnt[2] = TIMER_COUNT2;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign wr_do = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_idx = awaddr_ff[tie2_pkg::IDX_MSB:tie2_pkg::IDX_LSB];
  assign wr_map = awaddr_ff[tie2_pkg::ADDR_W-1:tie2_pkg::HI_LSB] == tie2_pkg::ADDR_HI_ZERO;

  // address and data are taken in either order, then held until the response
  always_ff @(posedge CLK) begin
    if (SRST) begin
      awready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (S_AXI_AWVALID && awready_ff) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b1;
      awaddr_ff <= S_AXI_AWADDR;
    end else if (wr_do) begin
      aw_hold_ff <= 1'b0;
    end else if (bvalid_ff && S_AXI_BREADY) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      wready_ff <= 1'b1;
      w_hold_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (S_AXI_WVALID && wready_ff) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b1;
      wdata_ff <= S_AXI_WDATA;
      wstrb_ff <= S_AXI_WSTRB;
    end else if (wr_do) begin
      w_hold_ff <= 1'b0;
    end else if (bvalid_ff && S_AXI_BREADY) begin
      wready_ff <= 1'b1;
    end
  end

  // write response, slverr outside the map
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= tie2_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_map ? tie2_pkg::RESP_OKAY : tie2_pkg::RESP_SLVERR;
    end else if (bvalid_ff && S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign rd_do = S_AXI_ARVALID && arready_ff;
  assign rd_idx = S_AXI_ARADDR[tie2_pkg::IDX_MSB:tie2_pkg::IDX_LSB];
  assign rd_map = S_AXI_ARADDR[tie2_pkg::ADDR_W-1:tie2_pkg::HI_LSB] == tie2_pkg::ADDR_HI_ZERO;

  // read mux, fixed bits folded in here
  always_comb begin
    rd_data = '0;
    if (rd_map) begin
      case (rd_idx)
        tie2_pkg::IDX_IOCTL: rd_data[3:0] = sel_ff;
        tie2_pkg::IDX_GENA: rd_data[15:0] = gena_ff;
        tie2_pkg::IDX_IEN0, 3'(tie2_pkg::IDX_IEN0 + 3'h1), 3'(tie2_pkg::IDX_IEN0 + 3'h2): begin
          rd_data[7:0] = ien_ff[2'(rd_idx - tie2_pkg::IDX_IEN0)] | tie2_pkg::IEN_FIXED;
        end
        default: begin
          rd_data[7:0] = tie2_pkg::STAT_FIXED | {2'h0, flag_ff[2'(rd_idx - tie2_pkg::IDX_STAT0)]};
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= tie2_pkg::RESP_OKAY;
    end else if (rd_do) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_map ? tie2_pkg::RESP_OKAY : tie2_pkg::RESP_SLVERR;
    end else if (rvalid_ff && S_AXI_RREADY) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event sampling
  // ----------------------------------------------------------------
  // blocks false wraps and edges in the first cycle after reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      started_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
      pin_prev_ff <= CH2_PIN_A_I;
    end
  end

  assign pin_rise = started_ff && CH2_PIN_A_I && !pin_prev_ff;
  assign pin_fall = started_ff && !CH2_PIN_A_I && pin_prev_ff;

  // compare match when the counter arrives at the register value
  assign cmp_match = !sel_ff.sel_a_bit3 && started_ff && cnt[2] == gena_ff && cnt[2] != cnt_prev_ff[2];

  // capture edge select, bit 2 not looked at
  always_comb begin
    cap_edge = 1'b0;
    if (sel_ff.sel_a_bit3) begin
      if (sel_ff.mode[1]) begin
        cap_edge = pin_rise || pin_fall;
      end else if (sel_ff.mode == tie2_pkg::CAP_FALL) begin
        cap_edge = pin_fall;
      end else begin
        cap_edge = pin_rise;
      end
    end
  end

  assign gen_evt[0] = CH0_GEN_EVT;
  assign gen_evt[1] = {2'h0, CH1_GEN_EVT};
  assign gen_evt[2] = {2'h0, CH2_GEN_B_EVT, cmp_match || cap_edge};

  // ----------------------------------------------------------------
  // channel 2 A io control, register and pin
  // ----------------------------------------------------------------
  assign ioctl_wr = wr_do && wr_map && wr_idx == tie2_pkg::IDX_IOCTL && wstrb_ff[0];
  assign nxt_sel = wdata_ff[3:0];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sel_ff <= tie2_pkg::SEL_RESET;
    end else if (ioctl_wr) begin
      sel_ff <= nxt_sel;
    end
  end

  // capture beats a bus write in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gena_ff <= tie2_pkg::GENA_RESET;
    end else if (cap_edge) begin
      gena_ff <= cnt[2];
    end else if (wr_do && wr_map && wr_idx == tie2_pkg::IDX_GENA) begin
      if (wstrb_ff[0]) begin
        gena_ff[7:0] <= wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        gena_ff[15:8] <= wdata_ff[15:8];
      end
    end
  end

  // output level: initial level on select write, then per mode on match
  always_ff @(posedge CLK) begin
    if (SRST) begin
      out_lvl_ff <= 1'b0;
    end else if (ioctl_wr) begin
      out_lvl_ff <= nxt_sel.sel_a_bit2;
    end else if (cmp_match) begin
      case (sel_ff.mode)
        tie2_pkg::MODE_LOW: out_lvl_ff <= 1'b0;
        tie2_pkg::MODE_HIGH: out_lvl_ff <= 1'b1;
        tie2_pkg::MODE_TOGGLE: out_lvl_ff <= !out_lvl_ff;
        default: out_lvl_ff <= out_lvl_ff;
      endcase
    end
  end

  // pin driven only in compare mode with a non-zero mode
  always_ff @(posedge CLK) begin
    if (SRST) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= !sel_ff.sel_a_bit3 && sel_ff.mode != tie2_pkg::MODE_OFF;
    end
  end

  assign CH2_PIN_A_O = out_lvl_ff;
  assign CH2_PIN_A_OE = oe_ff;

  // ----------------------------------------------------------------
  // per-channel enables, flags and requests
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < tie2_pkg::NUM_CH; ch++) begin : g_ch
    localparam logic [7:0] IEN_MASK = (ch == 0) ? tie2_pkg::IEN_MASK_CH0 : tie2_pkg::IEN_MASK_CH12;
    localparam logic [5:0] FLAG_MASK = (ch == 0) ? tie2_pkg::FLAG_MASK_CH0 : tie2_pkg::FLAG_MASK_CH12;
    localparam logic [2:0] IEN_IDX = 3'(tie2_pkg::IDX_IEN0 + 3'(ch));
    localparam logic [2:0] STAT_IDX = 3'(tie2_pkg::IDX_STAT0 + 3'(ch));
    logic ovf;
    logic unf;
    logic stat_wr;
    logic stat_rd;
    logic [5:0] set;
    logic [5:0] clr;

    assign ovf = started_ff && cnt_prev_ff[ch] == tie2_pkg::CNT_MAX && cnt[ch] == tie2_pkg::CNT_ZERO;
    assign unf = started_ff && cnt_prev_ff[ch] == tie2_pkg::CNT_ZERO && cnt[ch] == tie2_pkg::CNT_MAX;
    assign set = {unf, ovf, gen_evt[ch]} & FLAG_MASK;
    assign stat_wr = wr_do && wr_map && wr_idx == STAT_IDX && wstrb_ff[0];
    assign stat_rd = rd_do && rd_map && rd_idx == STAT_IDX;
    assign clr = stat_wr ? (~wdata_ff[5:0] & armed_ff[ch]) : tie2_pkg::FLAG_NONE;

    // counter history for wrap and match detection
    always_ff @(posedge CLK) begin
      if (SRST) begin
        cnt_prev_ff[ch] <= tie2_pkg::CNT_ZERO;
      end else begin
        cnt_prev_ff[ch] <= cnt[ch];
      end
    end

    // only writable bits are stored; reserved ones read back fixed
    always_ff @(posedge CLK) begin
      if (SRST) begin
        ien_ff[ch] <= tie2_pkg::IEN_FIXED & IEN_MASK;
      end else if (wr_do && wr_map && wr_idx == IEN_IDX && wstrb_ff[0]) begin
        ien_ff[ch] <= wdata_ff[7:0] & IEN_MASK;
      end
    end

    // sticky flags, set beats clear
    always_ff @(posedge CLK) begin
      if (SRST) begin
        flag_ff[ch] <= tie2_pkg::FLAG_NONE;
      end else begin
        flag_ff[ch] <= (flag_ff[ch] & ~clr) | set;
      end
    end

    // a flag may be cleared only after it was read as 1
    always_ff @(posedge CLK) begin
      if (SRST) begin
        armed_ff[ch] <= tie2_pkg::FLAG_NONE;
      end else begin
        armed_ff[ch] <= (armed_ff[ch] & flag_ff[ch] & ~clr) | (stat_rd ? flag_ff[ch] : tie2_pkg::FLAG_NONE);
      end
    end

    // request gating, enable bits line up with flag bits
    always_ff @(posedge CLK) begin
      if (SRST) begin
        irq_ff[ch] <= tie2_pkg::FLAG_NONE;
      end else begin
        irq_ff[ch] <= flag_ff[ch] & ien_ff[ch][5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign GEN_A_IRQ = {irq_ff[2][0], irq_ff[1][0], irq_ff[0][0]};
  assign GEN_B_IRQ = {irq_ff[2][1], irq_ff[1][1], irq_ff[0][1]};
  assign GEN_C_IRQ = irq_ff[0][2];
  assign GEN_D_IRQ = irq_ff[0][3];
  assign OVERFLOW_IRQ = {irq_ff[2][4], irq_ff[1][4], irq_ff[0][4]};
  assign UNDERFLOW_IRQ = {irq_ff[2][5], irq_ff[1][5]};

endmodule

// ===== verification/tie2_far_mdl.sv
// far-side model: the timer counter that feeds the count inputs
// assumes the bench loads it during reset before the block looks at it
`timescale 1ns/1ps
module tie2_far_mdl (
  input wire logic clk,
  input wire logic ld,
  input wire logic [15:0] ld_val,
  input wire logic run,
  input wire logic dn,
  output logic [15:0] cnt_ff
);
  // load, or step one count per cycle up or down; wraps both ways
  always_ff @(posedge clk) begin
    if (ld) begin
      cnt_ff <= ld_val;
    end else if (run) begin
      cnt_ff <= dn ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
    end
  end
endmodule

// ===== verification/tie2_top_props.sv
// checker for tie2_top: enable writes against the request outputs
// assumes write address and data are taken at one edge, as the bench does
`timescale 1ns/1ps
module tie2_top_props (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [2:0] GEN_A_IRQ,
  input wire logic [2:0] GEN_B_IRQ,
  input wire logic GEN_C_IRQ,
  input wire logic GEN_D_IRQ,
  input wire logic [2:0] OVERFLOW_IRQ,
  input wire logic [1:0] UNDERFLOW_IRQ
);
  // ----------------------------------------------------------------
  // enable byte write taken; request drops two edges after it lands
  // ----------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic wr_go;
  assign wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_WSTRB[0];

  property p_rst_quiet;
    $fell(SRST) |-> OVERFLOW_IRQ == 3'h0 && UNDERFLOW_IRQ == 2'h0 && GEN_A_IRQ == 3'h0 && GEN_B_IRQ == 3'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("request high after reset");
  property p_ovf_gate;
    wr_go && S_AXI_AWADDR == 8'h00 && !S_AXI_WDATA[4] |-> ##3 !OVERFLOW_IRQ[0];
  endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request not blocked");
  property p_unf_gate;
    wr_go && S_AXI_AWADDR == 8'h04 && !S_AXI_WDATA[5] |-> ##3 !UNDERFLOW_IRQ[0];
  endproperty
  a_unf_gate: assert property (p_unf_gate) else $error("underflow request not blocked");
  property p_d_gate;
    wr_go && S_AXI_AWADDR == 8'h00 && !S_AXI_WDATA[3] |-> ##3 !GEN_D_IRQ [*2];
  endproperty
  a_d_gate: assert property (p_d_gate) else $error("d request not blocked");
  property p_c_gate;
    wr_go && S_AXI_AWADDR == 8'h00 && !S_AXI_WDATA[2] |-> ##3 !GEN_C_IRQ;
  endproperty
  a_c_gate: assert property (p_c_gate) else $error("c request not blocked");
  property p_b_gate;
    wr_go && S_AXI_AWADDR == 8'h04 && !S_AXI_WDATA[1] |=> ##2 !GEN_B_IRQ[1];
  endproperty
  a_b_gate: assert property (p_b_gate) else $error("b request not blocked");
  property p_a_gate;
    wr_go && S_AXI_AWADDR == 8'h00 && !S_AXI_WDATA[0] |-> ##3 !GEN_A_IRQ[0];
  endproperty
  a_a_gate: assert property (p_a_gate) else $error("a request not blocked");
  property p_ch2_drop;
    wr_go && S_AXI_AWADDR == 8'h08 && (S_AXI_WDATA[7:0] & 8'h33) == 8'h00
      |-> ##3 {GEN_A_IRQ[2], GEN_B_IRQ[2], OVERFLOW_IRQ[2], UNDERFLOW_IRQ[1]} == 4'h0;
  endproperty
  a_ch2_drop: assert property (p_ch2_drop) else $error("channel 2 requests stay high");
endmodule

bind tie2_top tie2_top_props u_props (.CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .GEN_A_IRQ, .GEN_B_IRQ, .GEN_C_IRQ,
  .GEN_D_IRQ, .OVERFLOW_IRQ, .UNDERFLOW_IRQ);

// ===== verification/tie2_top_tb.sv
// bench for tie2_top: bus tasks, counter and pin stimulus, self checks
// assumes tie2_pkg, the far-side model and the checker are compiled first
`timescale 1ns/1ps
module tie2_top_tb;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [3:0] CH0_GEN_EVT = 4'h0;
  logic [1:0] CH1_GEN_EVT = 2'h0;
  logic CH2_GEN_B_EVT = 1'b0, CH2_PIN_A_I = 1'b0;
  logic ld = 1'b1, run = 1'b0, dn = 1'b0;
  logic [15:0] ld_val = 16'h0, cnt, c1, c2, exp_gen;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic CH2_PIN_A_O, CH2_PIN_A_OE, GEN_C_IRQ, GEN_D_IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, UNDERFLOW_IRQ, rs, bs;
  logic [31:0] S_AXI_RDATA, rd;
  logic [2:0] GEN_A_IRQ, GEN_B_IRQ, OVERFLOW_IRQ;
  logic [7:0] dv;
  logic [3:0] md;
  logic [3:0] cmp_modes [4] = '{4'h5, 4'h2, 4'h3, 4'h7};
  logic [3:0] cap_modes [4] = '{4'h8, 4'h9, 4'ha, 4'hc};
  int err_count = 0;
  int check_count = 0;

  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  always #10 CLK = ~CLK;
  tie2_far_mdl far (.clk(CLK), .ld(ld), .ld_val(ld_val), .run(run), .dn(dn), .cnt_ff(cnt));
  tie2_top dut (.CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWPROT, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARPROT, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .TIMER_COUNT0(cnt), .TIMER_COUNT1(cnt), .TIMER_COUNT2(cnt), .CH0_GEN_EVT, .CH1_GEN_EVT, .CH2_GEN_B_EVT,
    .CH2_PIN_A_I, .CH2_PIN_A_O, .CH2_PIN_A_OE, .GEN_A_IRQ, .GEN_B_IRQ, .GEN_C_IRQ, .GEN_D_IRQ,
    .OVERFLOW_IRQ, .UNDERFLOW_IRQ);

  // ----------------------------------------------------------------
  // expectations, compare and verdict
  // ----------------------------------------------------------------
  function automatic logic [31:0] ien_exp(input int ch, input logic [7:0] d);
    ien_exp = {24'h0, (d & (ch == 0 ? tie2_pkg::IEN_MASK_CH0 : tie2_pkg::IEN_MASK_CH12)) | tie2_pkg::IEN_FIXED};
  endfunction

  function automatic logic pin_exp(input logic [3:0] m);
    pin_exp = (m[1:0] == 2'h1) ? 1'b0 : (m[1:0] == 2'h2) ? 1'b1 : ~m[2];
  endfunction

  task automatic summarize();
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 40) begin
      chk("bus_wait", 32'h0, 32'h1);
      summarize();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // ----------------------------------------------------------------
  // bus master and counter stimulus
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWPROT <= 3'($urandom);
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 40);
    bs = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    tmo(n);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARPROT <= 3'($urandom);
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 40);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    tmo(n);
  endtask

  task automatic cnt_go(input logic [15:0] v, input logic down, input int n);
    @(posedge CLK);
    ld <= 1'b1;
    ld_val <= v;
    dn <= down;
    @(posedge CLK);
    ld <= 1'b0;
    run <= n > 0;
    repeat (n) @(posedge CLK);
    if (n > 0) run <= 1'b0;
    cyc(3);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h54cdc516));
    cyc(10);
    SRST <= 1'b0;
    ld <= 1'b0;
    // enable reset value, then all-ones, all-zeros and random writes
    for (int ch = 0; ch < 3; ch++) begin
      rd_reg(8'(ch * 4), rd, rs);
      chk("ien_reset", 32'h40, rd);
      for (int k = 0; k < 3; k++) begin
        dv = (k == 0) ? 8'h7f : (k == 1) ? 8'h40 : {2'h1, 6'($urandom)};
        wr(8'(ch * 4), {24'($urandom), dv});
        rd_reg(8'(ch * 4), rd, rs);
        chk("ien", ien_exp(ch, dv), rd);
      end
    end
    rd_reg(8'h20, rd, rs);
    chk("unmapped_resp", {30'h0, tie2_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(8'h20, 32'h0);
    chk("unmapped_bresp", {30'h0, tie2_pkg::RESP_SLVERR}, {30'h0, bs});
    wr(8'h00, 32'h5f);
    wr(8'h04, 32'h73);
    wr(8'h08, 32'h73);
    // overflow wrap, gating and clear after read
    cnt_go(16'hfffe, 1'b0, 4);
    chk("ovf_irq", 32'h7, {29'h0, OVERFLOW_IRQ});
    chk("unf_irq", 32'h0, {30'h0, UNDERFLOW_IRQ});
    wr(8'h00, 32'h4f);
    cyc(2);
    chk("ovf_irq", 32'h6, {29'h0, OVERFLOW_IRQ});
    wr(8'h14, 32'h0);
    cyc(2);
    chk("ovf_irq", 32'h6, {29'h0, OVERFLOW_IRQ});
    rd_reg(8'h14, rd, rs);
    chk("stat1", 32'hd0, rd);
    wr(8'h14, 32'hff);
    cyc(2);
    chk("ovf_irq", 32'h6, {29'h0, OVERFLOW_IRQ});
    wr(8'h14, 32'h0);
    cyc(2);
    chk("ovf_irq", 32'h4, {29'h0, OVERFLOW_IRQ});
    // underflow wrap and its gate
    cnt_go(16'h0001, 1'b1, 4);
    chk("unf_irq", 32'h3, {30'h0, UNDERFLOW_IRQ});
    wr(8'h04, 32'h53);
    cyc(2);
    chk("unf_irq", 32'h2, {30'h0, UNDERFLOW_IRQ});
    // capture/compare event pulses; ch2 a already matched at ffff
    @(posedge CLK);
    CH0_GEN_EVT <= 4'hf;
    CH1_GEN_EVT <= 2'h3;
    CH2_GEN_B_EVT <= 1'b1;
    @(posedge CLK);
    CH0_GEN_EVT <= 4'h0;
    CH1_GEN_EVT <= 2'h0;
    CH2_GEN_B_EVT <= 1'b0;
    cyc(3);
    chk("gen_irq", 32'hff, {24'h0, GEN_A_IRQ, GEN_B_IRQ, GEN_C_IRQ, GEN_D_IRQ});
    wr(8'h00, 32'h40);
    wr(8'h04, 32'h51);
    cyc(2);
    chk("gen_irq", 32'hd0, {24'h0, GEN_A_IRQ, GEN_B_IRQ, GEN_C_IRQ, GEN_D_IRQ});
    // compare output modes: initial level, then level after one match
    for (int k = 0; k < 4; k++) begin
      md = cmp_modes[k];
      c1 = 16'($urandom) | 16'h0010;
      wr(8'h1c, {16'h0, c1});
      wr(8'h0c, {28'h0, md});
      cyc(2);
      chk("pin_init", {30'h0, 1'b1, md[2]}, {30'h0, CH2_PIN_A_OE, CH2_PIN_A_O});
      cnt_go(c1 - 16'h0008, 1'b0, 12);
      chk("pin_match", {30'h0, 1'b1, pin_exp(md)}, {30'h0, CH2_PIN_A_OE, CH2_PIN_A_O});
    end
    exp_gen = c1;
    wr(8'h0c, 32'h4);
    cyc(2);
    chk("pin_oe", 32'h0, {31'h0, CH2_PIN_A_OE});
    // input capture on rising, falling and both edges
    for (int k = 0; k < 4; k++) begin
      md = cap_modes[k];
      wr(8'h0c, {28'h0, md});
      c1 = 16'($urandom);
      c2 = 16'($urandom);
      cnt_go(c1, 1'b0, 0);
      @(posedge CLK);
      CH2_PIN_A_I <= 1'b1;
      cyc(3);
      if (md[1] || !md[0]) exp_gen = c1;
      rd_reg(8'h1c, rd, rs);
      chk("cap_rise", {16'h0, exp_gen}, rd);
      cnt_go(c2, 1'b0, 0);
      @(posedge CLK);
      CH2_PIN_A_I <= 1'b0;
      cyc(3);
      if (md[1] || md[0]) exp_gen = c2;
      rd_reg(8'h1c, rd, rs);
      chk("cap_fall", {16'h0, exp_gen}, rd);
    end
    summarize();
  end
endmodule
